//--- pkg/lsw_pkg.sv
`default_nettype none
package lsw_pkg;
  localparam int LSW_CLK_MHZ = 40;
  localparam int LSW_ADDR_W = 8;
  localparam int LSW_DATA_W = 4;
  // Times in ns, slowest grade
  localparam int LSW_STROBE_LOW_NS = 350;
  localparam int LSW_STROBE_HIGH_NS = 150;
  localparam int LSW_WRITE_SETUP_NS = 210;
  localparam int LSW_OUTPUT_OFF_NS = 180;
  localparam int LSW_DATA_SETUP_NS = 170;
  localparam int LSW_ADDR_HOLD_NS = 70;
  localparam int LSW_GATE_ON_NS = 180;
  // Least times round up to whole cycles
  localparam int LSW_STROBE_LOW_CYC = (LSW_STROBE_LOW_NS * LSW_CLK_MHZ + 999) / 1000;
  localparam int LSW_STROBE_HIGH_CYC = (LSW_STROBE_HIGH_NS * LSW_CLK_MHZ + 999) / 1000;
  localparam int LSW_WRITE_SETUP_CYC = (LSW_WRITE_SETUP_NS * LSW_CLK_MHZ + 999) / 1000;
  localparam int LSW_OUTPUT_OFF_CYC = (LSW_OUTPUT_OFF_NS * LSW_CLK_MHZ + 999) / 1000;
  localparam int LSW_DATA_SETUP_CYC = (LSW_DATA_SETUP_NS * LSW_CLK_MHZ + 999) / 1000;
  localparam int LSW_ADDR_HOLD_CYC = (LSW_ADDR_HOLD_NS * LSW_CLK_MHZ + 999) / 1000;
  localparam int LSW_GATE_ON_CYC = (LSW_GATE_ON_NS * LSW_CLK_MHZ + 999) / 1000;
  localparam int LSW_CNT_W = 8;
  typedef enum logic [2:0] {
    LSW_IDLE, LSW_LATCH, LSW_WAIT_OFF, LSW_DRIVE, LSW_GATE_READ, LSW_RELEASE, LSW_RECOVER
  } lsw_state_t;
endpackage : lsw_pkg
`default_nettype wire

//--- hw/lsw_write_ctrl.sv
// Function
// - Present second select low at strobe fall
// - Write setup met before strobe and gate rise
// - Write enable may stay low across burst
// - Burst data timed to first strobe/gate rise
// - Wait output-off delay before driving data
// - Hold strobe high during retention
// - Keep a select deselected during retention
// - Wait strobe-high interval after power returns
`default_nettype none
module lsw_write_ctrl
  import lsw_pkg::*;
#(
  parameter int ADDR_W = LSW_ADDR_W,
  parameter int DATA_W = LSW_DATA_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_data,
  input wire logic req_burst,
  input wire logic retain,
  input wire logic power_good,
  output logic done,
  output logic [DATA_W-1:0] old_data,
  output logic strobe_n,
  output logic gate_select_n,
  output logic latched_select_n,
  output logic write_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_in
);
  // Widths must be usable and the strobe-low count must fit the shared down-counter
  if (ADDR_W < 1 || DATA_W < 1 || LSW_STROBE_LOW_CYC >= (1 << LSW_CNT_W)) begin : g_bad_cfg
    $error("lsw_write_ctrl: widths or counts out of range");
  end

  lsw_state_t state;
  logic [LSW_CNT_W-1:0] cnt;
  logic burst_run;
  logic powered;
  logic [ADDR_W-1:0] hold_addr;

  wire logic cnt_zero = (cnt == '0);
  // Never start a cycle in retention or before supply recovery
  wire logic may_start = req_valid && !retain && powered;
  assign req_ready = (state == LSW_IDLE) && !retain && powered;

  function automatic logic [LSW_CNT_W-1:0] lsw_cyc(input int n);
    lsw_cyc = LSW_CNT_W'(n > 0 ? n - 1 : 0);
  endfunction : lsw_cyc

  // Supply recovery: one strobe-high interval after power is good
  logic [LSW_CNT_W-1:0] pwr_cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_cnt <= '0;
      powered <= 1'b0;
    end else if (!power_good) begin
      pwr_cnt <= '0;
      powered <= 1'b0;
    end else if (!powered) begin
      if (pwr_cnt == lsw_cyc(LSW_STROBE_HIGH_CYC)) begin
        powered <= 1'b1;
      end else begin
        pwr_cnt <= pwr_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= LSW_IDLE;
      cnt <= '0;
      burst_run <= 1'b0;
    end else begin
      unique case (state)
        LSW_IDLE: begin
          if (may_start) begin
            state <= LSW_LATCH;
            cnt <= lsw_cyc(LSW_ADDR_HOLD_CYC);
          end
        end
        LSW_LATCH: begin
          // Address held past strobe fall, then gate low one output-on delay before write
          if (cnt_zero && gate_select_n) begin
            cnt <= lsw_cyc(LSW_GATE_ON_CYC);
          end else if (cnt_zero) begin
            state <= LSW_WAIT_OFF;
            cnt <= lsw_cyc(LSW_OUTPUT_OFF_CYC);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        LSW_WAIT_OFF: begin
          if (cnt_zero || burst_run) begin
            state <= LSW_DRIVE;
            cnt <= lsw_cyc(LSW_WRITE_SETUP_CYC > LSW_DATA_SETUP_CYC ? LSW_WRITE_SETUP_CYC : LSW_DATA_SETUP_CYC);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        LSW_DRIVE: begin
          // Covers data setup as well as write setup
          if (cnt_zero) begin
            state <= LSW_GATE_READ;
            cnt <= lsw_cyc(LSW_STROBE_LOW_CYC);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        LSW_GATE_READ: begin
          if (cnt_zero) begin
            state <= LSW_RELEASE;
            burst_run <= req_burst;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        LSW_RELEASE: begin
          state <= LSW_RECOVER;
          cnt <= lsw_cyc(LSW_STROBE_HIGH_CYC);
        end
        LSW_RECOVER: begin
          if (cnt_zero) begin
            state <= LSW_IDLE;
            if (!req_valid || !req_burst) begin
              burst_run <= 1'b0;
            end
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // Pin drive; strobe and gate rise together to close the window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_n <= 1'b1;
      gate_select_n <= 1'b1;
      latched_select_n <= 1'b1;
      write_n <= 1'b1;
      dq_oe <= 1'b0;
      dq_out <= '0;
      hold_addr <= '0;
    end else begin
      unique case (state)
        LSW_IDLE: begin
          strobe_n <= 1'b1;
          gate_select_n <= 1'b1;
          if (may_start) begin
            hold_addr <= req_addr;
            dq_out <= req_data;
            // Address and second select settle one cycle before the strobe falls
            latched_select_n <= 1'b0;
          end else begin
            latched_select_n <= 1'b1;
          end
        end
        LSW_LATCH: begin
          strobe_n <= 1'b0;
          if (cnt_zero && gate_select_n) begin
            gate_select_n <= 1'b0;
          end else if (cnt_zero) begin
            write_n <= 1'b0;
          end
        end
        LSW_WAIT_OFF: begin
          if (cnt_zero || burst_run) begin
            dq_oe <= 1'b1;
          end
        end
        LSW_DRIVE: begin
          dq_oe <= 1'b1;
        end
        LSW_GATE_READ: begin
          if (cnt_zero) begin
            strobe_n <= 1'b1;
            gate_select_n <= 1'b1;
          end
        end
        LSW_RELEASE: begin
          latched_select_n <= 1'b1;
          if (!burst_run) begin
            write_n <= 1'b1;
            dq_oe <= 1'b0;
          end
        end
        LSW_RECOVER: begin
          if (cnt_zero && !(req_valid && req_burst)) begin
            write_n <= 1'b1;
            dq_oe <= 1'b0;
          end
        end
      endcase
    end
  end

  assign addr = hold_addr;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done <= 1'b0;
      old_data <= '0;
    end else begin
      done <= (state == LSW_RELEASE);
      // Read side of a combined cycle is only sampled when not driving
      if (state == LSW_LATCH && cnt_zero && !gate_select_n && !dq_oe) begin
        old_data <= dq_in;
      end
    end
  end
endmodule : lsw_write_ctrl
`default_nettype wire

//--- test/lsw_write_ctrl_properties.sv
`default_nettype none
module lsw_write_ctrl_properties #(
  parameter int DATA_W = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_ready,
  input wire logic retain,
  input wire logic power_good,
  input wire logic done,
  input wire logic strobe_n,
  input wire logic gate_select_n,
  input wire logic latched_select_n,
  input wire logic write_n,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_SEL: assert property ($fell(strobe_n) |-> !latched_select_n)
    else $error("select high at strobe fall");
  AST_RET_E: assert property (retain && strobe_n |=> strobe_n)
    else $error("strobe fell in retention");
  AST_RET_G: assert property (retain && gate_select_n |=> gate_select_n)
    else $error("gate fell in retention");
  AST_OFF: assert property ($fell(write_n) |-> !dq_oe [*8])
    else $error("data driven too early");
  AST_SETUP: assert property ($rose(strobe_n) |-> !$past(write_n, 9))
    else $error("write setup short");
  AST_DATA: assert property ($rose(strobe_n) |-> dq_oe && $past(dq_oe, 7) && $stable(dq_out))
    else $error("data setup short");
  AST_OE: assert property (dq_oe |-> !write_n)
    else $error("bus driven outside write");
  AST_PWR: assert property ($rose(power_good) |-> !req_ready [*6])
    else $error("ready before supply settled");
  // Burst shows as done while write enable stays low
  cover property ($rose(dq_oe));
  cover property (done && !write_n);
  cover property (retain && strobe_n);
  cover property ($fell(gate_select_n) && write_n);
endmodule : lsw_write_ctrl_properties
bind lsw_write_ctrl lsw_write_ctrl_properties #(.DATA_W(DATA_W)) u_props (.clk, .rst_b, .req_ready, .retain,
  .power_good, .done, .strobe_n, .gate_select_n, .latched_select_n, .write_n, .dq_out, .dq_oe);
`default_nettype wire

//--- test/lsw_ram_model.sv
`default_nettype none
module lsw_ram_model (
  input wire logic strobe_n,
  input wire logic gate_select_n,
  input wire logic latched_select_n,
  input wire logic write_n,
  input wire logic [7:0] addr,
  input wire logic [3:0] dq,
  output logic [3:0] q,
  output logic q_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mem [256];
  logic [7:0] la;
  logic ls = 1'b1;
  // Late address changes are ignored until the next fall
  always @(negedge strobe_n) begin
    la = addr;
    ls = latched_select_n;
  end
  // Last value before the window closes is the one kept
  always @* if (!strobe_n && !write_n && !gate_select_n && !ls) mem[la] = dq;
  assign q_oe = !strobe_n && !gate_select_n && write_n && !ls;
  assign q = mem[la];
endmodule : lsw_ram_model
`default_nettype wire

//--- test/lsw_write_ctrl_tb.sv
`default_nettype none
module lsw_write_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0, req_burst = 1'b0, retain = 1'b0, power_good = 1'b1;
  logic [7:0] req_addr = 8'h00, addr;
  logic [3:0] req_data = 4'h0, old_data, dq_out, dq_in, q, pat = 4'hA;
  logic req_ready, done, strobe_n, gate_select_n, latched_select_n, write_n, dq_oe, q_oe;
  int miscompares = 0;
  int checks = 0;
  lsw_write_ctrl dut (.clk, .rst_b, .req_valid, .req_ready, .req_addr, .req_data, .req_burst,
    .retain, .power_good, .done, .old_data, .strobe_n, .gate_select_n, .latched_select_n,
    .write_n, .addr, .dq_out, .dq_oe, .dq_in);
  lsw_ram_model u_ram (.strobe_n, .gate_select_n, .latched_select_n, .write_n, .addr,
    .dq(dq_in), .q, .q_oe);
  // Undriven bus changes every cycle so stale data never passes
  always @(posedge clk) pat <= #2 ~pat;
  assign dq_in = dq_oe ? dq_out : (q_oe ? q : pat);
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test;
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [3:0] d, input logic b);
    int n;
    n = 0;
    req_addr = a;
    req_data = d;
    req_burst = b;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 300) begin
      @(posedge clk);
      #2;
      n++;
    end
    @(posedge clk);
    #2;
    req_valid = 1'b0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk);
      #2;
      n++;
    end
    chk("done pulse", 8'h01, {7'h0, done});
    chk("stored word", {4'h0, d}, {4'h0, u_ram.mem[a]});
  endtask : wr
  task automatic t_edges;
    wr(8'h00, 4'hF, 1'b0);
    wr(8'hFF, 4'h0, 1'b0);
    chk("word at zero", 8'h0F, {4'h0, u_ram.mem[0]});
    wr(8'h00, 4'h5, 1'b0);
    chk("old word read back", 8'h0F, {4'h0, old_data});
  endtask : t_edges
  task automatic t_burst;
    wr(8'h12, 4'h3, 1'b1);
    wr(8'h13, 4'hC, 1'b1);
    wr(8'h14, 4'h9, 1'b0);
    chk("first burst word", 8'h03, {4'h0, u_ram.mem[8'h12]});
  endtask : t_burst
  task automatic t_retain;
    retain = 1'b1;
    req_valid = 1'b1;
    repeat (20) @(posedge clk);
    #2;
    chk("strobe held", 8'h01, {7'h0, strobe_n});
    chk("gate held", 8'h01, {7'h0, gate_select_n});
    retain = 1'b0;
    req_valid = 1'b0;
  endtask : t_retain
  task automatic t_power;
    power_good = 1'b0;
    @(posedge clk);
    #2;
    power_good = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    chk("ready while settling", 8'h00, {7'h0, req_ready});
    wr(8'h55, 4'h6, 1'b0);
  endtask : t_power
  initial begin
    repeat (16) @(posedge clk);
    #2;
    rst_b = 1'b1;
    t_edges();
    t_burst();
    t_retain();
    t_power();
    stop_test();
  end
  initial begin
    #50000;
    miscompares++;
    stop_test();
  end
endmodule : lsw_write_ctrl_tb
`default_nettype wire
